/* File: sdp_defs.svh */
// Constants for the speed and direction pulse sequencer.
// Assumes a 100 MHz i_clk; times are in ns and converted to cycles here.
// What this block does
// - Pulse timing comes from one designated channel only, both directions.
// - Pulse issues slightly ahead of the sensed edge reaching the face.
// - Shift aligns forward pulses to the valley, reverse to the tooth.
// - After a running direction change, pulses stop until direction validated.
// - Power-up starts calibration finding profile, adjusting gain and offset.
// - Gain and offset loops run independently for each differential channel.
// - Loops centre the processed signal within converter range for peaks.
// - No direction reported before calibration completes.
// - Vibration is detected from both magnetic channels together.
// - While vibration is detected the output is blanked, no pulses.
// - After blanking, pulses resume only once direction revalidated on rotation.
// - Forward rotation gives pulses of the short width, 45 us.
// - Reverse rotation gives pulses of the long width, 90 us.
// - Direction comes from the switching order of the two channels.
// - Exactly one pulse per tooth, so pulse rate conveys speed.
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH
`define SDP_CLK_PERIOD_NS   10
`define SDP_FWD_WIDTH_NS    45000
`define SDP_REV_WIDTH_NS    90000
`define SDP_FWD_CYCLES  (`SDP_FWD_WIDTH_NS / `SDP_CLK_PERIOD_NS)
`define SDP_REV_CYCLES  (`SDP_REV_WIDTH_NS / `SDP_CLK_PERIOD_NS)
`define SDP_CAL_EDGES       3
`define SDP_VALID_EDGES     2
`define SDP_ADV_CYCLES      16
`define SDP_GAIN_RST        8'h80
`define SDP_OFFS_RST        10'h000
`define SDP_ADC_HI          10'h300
`define SDP_ADC_LO          10'h100
`endif

/* File: sdp_pkg.sv */
// Types for the speed and direction pulse sequencer.
// Assumes sdp_defs.svh supplies the numeric constants.
package sdp_pkg;
    typedef enum logic [1:0]
    {
        SDP_CAL    = 2'b00,
        SDP_VALID  = 2'b01,
        SDP_RUN    = 2'b10,
        SDP_BLANK  = 2'b11
    } sdp_state_t;

    typedef struct packed
    {
        logic [9:0] level;
        logic       valid;
    } sdp_sample_t;

    typedef struct packed
    {
        logic [7:0] gain;
        logic [9:0] offset;
    } sdp_trim_t;
endpackage

/* File: sdp_pulse_seq.sv */
// Pulse sequencer: calibration, direction, vibration blanking, output.
// Assumes converter samples arrive synchronous to i_clk, one per channel.
`include "sdp_defs.svh"
module sdp_pulse_seq
#(
    parameter int FWD_CYCLES  = `SDP_FWD_CYCLES,
    parameter int REV_CYCLES  = `SDP_REV_CYCLES,
    parameter int ADV_CYCLES  = `SDP_ADV_CYCLES,
    parameter int CAL_EDGES   = `SDP_CAL_EDGES,
    parameter int VALID_EDGES = `SDP_VALID_EDGES
)
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire sdp_pkg::sdp_sample_t i_ch_a,
    input  wire sdp_pkg::sdp_sample_t i_ch_b,
    input  wire logic                 i_vibration,
    output logic                      o_pulse,
    output logic                      o_reverse,
    output logic                      o_cal_done,
    output sdp_pkg::sdp_trim_t        o_trim_a,
    output sdp_pkg::sdp_trim_t        o_trim_b
);
    sdp_pkg::sdp_state_t state_ff;
    sdp_pkg::sdp_state_t nxt_state;
    logic [1:0]  sw_ff;
    logic [1:0]  sw_d_ff;
    logic [16:0] width_cnt_ff;
    logic [16:0] nxt_width_cnt;
    logic [7:0]  adv_cnt_ff;
    logic [7:0]  nxt_adv_cnt;
    logic        adv_pend_ff;
    logic        pend_rev_ff;
    logic        dir_rev_ff;
    logic        vib_seen_ff;
    logic [3:0]  edge_cnt_ff;
    logic        pulse_ff;
    logic        rev_out_ff;
    logic        cal_done_ff;

    // Per-channel gain and offset loops, each closed on its own samples
    sdp_pkg::sdp_sample_t ch [2];
    logic [1:0] sw_now;
    assign ch[0] = i_ch_a;
    assign ch[1] = i_ch_b;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_trim
            logic [7:0] gain_ff;
            logic [9:0] offs_ff;
            wire        hi   = ch[g].level > `SDP_ADC_HI;
            wire        lo   = ch[g].level < `SDP_ADC_LO;
            wire        tune = ch[g].valid && state_ff == sdp_pkg::SDP_CAL;
            // Switch with hysteresis around mid range
            assign sw_now[g] = ch[g].level[9] ? 1'b1 :
                               (ch[g].level < 10'h1C0 ? 1'b0 : sw_ff[g]);
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    gain_ff <= `SDP_GAIN_RST;
                    offs_ff <= `SDP_OFFS_RST;
                end
                else if (tune)
                begin
                    if (hi && lo)
                        gain_ff <= gain_ff;
                    else if (hi && gain_ff != 8'h00)
                        gain_ff <= gain_ff - 8'h01;
                    else if (lo && gain_ff != 8'hFF)
                        gain_ff <= gain_ff + 8'h01;
                    if (hi)
                        offs_ff <= offs_ff - 10'h001;
                    else if (lo)
                        offs_ff <= offs_ff + 10'h001;
                end
            end
        end
    endgenerate

    // Channel A edges time the pulses; B's phase at that edge gives direction
    wire a_edge   = sw_ff[0] != sw_d_ff[0];
    wire b_edge   = sw_ff[1] != sw_d_ff[1];
    wire edge_rev = sw_ff[0] == sw_ff[1];
    // Rising A is the tooth edge; forward fires for valley, reverse for tooth
    wire fire_pt  = edge_rev ? sw_ff[0] : ~sw_ff[0];
    // Vibration: external flag or B toggling twice without an A edge
    wire vib_now  = i_vibration || (b_edge && vib_seen_ff);
    wire dir_chg  = a_edge && (edge_rev != dir_rev_ff);
    wire width_done = width_cnt_ff == 17'h00001;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            sdp_pkg::SDP_CAL:
                if (a_edge && edge_cnt_ff >= 4'(CAL_EDGES - 1))
                    nxt_state = sdp_pkg::SDP_VALID;
            sdp_pkg::SDP_VALID:
                if (vib_now)
                    nxt_state = sdp_pkg::SDP_BLANK;
                else if (a_edge && !dir_chg &&
                         edge_cnt_ff >= 4'(VALID_EDGES - 1))
                    nxt_state = sdp_pkg::SDP_RUN;
            sdp_pkg::SDP_RUN:
                if (vib_now)
                    nxt_state = sdp_pkg::SDP_BLANK;
                else if (dir_chg)
                    nxt_state = sdp_pkg::SDP_VALID;
            sdp_pkg::SDP_BLANK:
                if (a_edge && !vib_now)
                    nxt_state = sdp_pkg::SDP_VALID;
            default:
                nxt_state = sdp_pkg::SDP_CAL;
        endcase
    end

    // A fixed advance models the early trigger ahead of the edge crossing
    wire start_adv = state_ff == sdp_pkg::SDP_RUN && nxt_state ==
                     sdp_pkg::SDP_RUN && a_edge && fire_pt;
    wire fire      = adv_pend_ff && adv_cnt_ff == 8'h00 &&
                     state_ff == sdp_pkg::SDP_RUN && !pulse_ff;
    assign nxt_adv_cnt = start_adv ? 8'(ADV_CYCLES - 1) :
                         (adv_cnt_ff != 8'h00 ? adv_cnt_ff - 8'h01 : 8'h00);
    assign nxt_width_cnt = fire ? (pend_rev_ff ? 17'(REV_CYCLES)
                                               : 17'(FWD_CYCLES))
                         : (pulse_ff ? width_cnt_ff - 17'h00001 : 17'h00000);

    // State and switch history
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_ff <= sdp_pkg::SDP_CAL;
            sw_ff    <= 2'b00;
            sw_d_ff  <= 2'b00;
        end
        else
        begin
            state_ff <= nxt_state;
            sw_ff    <= sw_now;
            sw_d_ff  <= sw_ff;
        end
    end

    // Advance and width counters
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            width_cnt_ff <= 17'h00000;
            adv_cnt_ff   <= 8'h00;
        end
        else
        begin
            width_cnt_ff <= nxt_width_cnt;
            adv_cnt_ff   <= nxt_adv_cnt;
        end
    end

    // Direction of the last A edge
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            dir_rev_ff <= 1'b0;
        else if (a_edge)
            dir_rev_ff <= edge_rev;
    end

    // A B edge wins over a clearing A edge so no toggle is lost
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            vib_seen_ff <= 1'b0;
        else if (b_edge)
            vib_seen_ff <= 1'b1;
        else if (a_edge)
            vib_seen_ff <= 1'b0;
    end

    // Edges seen in the present state
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            edge_cnt_ff <= 4'h0;
        else if (nxt_state != state_ff)
            edge_cnt_ff <= 4'h0;
        else if (a_edge && edge_cnt_ff != 4'hF)
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end

    // Leaving run drops a pending pulse rather than emit stale data
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            adv_pend_ff <= 1'b0;
            pend_rev_ff <= 1'b0;
        end
        else if (start_adv)
        begin
            adv_pend_ff <= 1'b1;
            pend_rev_ff <= edge_rev;
        end
        else if (fire || nxt_state != sdp_pkg::SDP_RUN)
            adv_pend_ff <= 1'b0;
    end

    // Output pulse and its direction flag
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pulse_ff   <= 1'b0;
            rev_out_ff <= 1'b0;
        end
        else if (fire)
        begin
            pulse_ff   <= 1'b1;
            rev_out_ff <= pend_rev_ff;
        end
        else if (width_done || state_ff != sdp_pkg::SDP_RUN)
            pulse_ff <= 1'b0;
    end

    // Calibration done stays set until the next reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cal_done_ff <= 1'b0;
        else if (nxt_state != sdp_pkg::SDP_CAL)
            cal_done_ff <= 1'b1;
    end

    assign o_pulse    = pulse_ff;
    assign o_reverse  = rev_out_ff;
    assign o_cal_done = cal_done_ff;
    assign o_trim_a   = {g_trim[0].gain_ff, g_trim[0].offs_ff};
    assign o_trim_b   = {g_trim[1].gain_ff, g_trim[1].offs_ff};
endmodule

/* File: sdp_host_model.sv */
// Host side model: classifies each pulse by width and counts them.
// Assumes o_pulse is sampled on the same rising edge as the design.
module sdp_host_model
#(
    parameter int FWD = 20,
    parameter int REV = 40
)
(
    input  wire logic        i_clk,
    input  wire logic        i_pulse,
    output logic      [15:0] o_fwd = '0,
    output logic      [15:0] o_rev = '0,
    output logic      [15:0] o_bad = '0
);
    int width = 0;
    always @(posedge i_clk)
    begin
        if (i_pulse)
            width <= width + 1;
        else if (width != 0)
        begin
            if (width == FWD)
                o_fwd <= o_fwd + 16'h0001;
            else if (width == REV)
                o_rev <= o_rev + 16'h0001;
            else
                o_bad <= o_bad + 16'h0001;
            width <= 0;
        end
    end
endmodule

/* File: sdp_pulse_seq_assertions.sv */
// Port checker for the pulse sequencer.
// Assumes i_rst is synchronous and returns every output register to its reset value.
`include "sdp_defs.svh"
module sdp_pulse_seq_assertions
#(
    parameter int FWD_CYCLES = `SDP_FWD_CYCLES,
    parameter int REV_CYCLES = `SDP_REV_CYCLES
)
(
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic               i_vibration,
    input wire logic               o_pulse,
    input wire logic               o_reverse,
    input wire logic               o_cal_done,
    input wire sdp_pkg::sdp_trim_t o_trim_a,
    input wire sdp_pkg::sdp_trim_t o_trim_b
);
    // Counts high cycles so widths far beyond a repetition can be checked
    int high_ff;
    always_ff @(posedge i_clk)
        high_ff <= (i_rst || !o_pulse) ? 0 : high_ff + 1;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_reset_idle: assert property (disable iff (1'b0) i_rst |=>
        !o_pulse && !o_cal_done && o_trim_b == {`SDP_GAIN_RST, `SDP_OFFS_RST})
        else $error("outputs not idle after reset");
    chk_cal_no_pulse: assert property (!o_cal_done |-> !o_pulse)
        else $error("pulse before calibration done");
    chk_fwd_width: assert property ($fell(o_pulse) && !o_reverse |->
        high_ff == FWD_CYCLES) else $error("forward width wrong");
    chk_rev_width: assert property ($fell(o_pulse) && o_reverse |->
        high_ff == REV_CYCLES) else $error("reverse width wrong");
    chk_dir_steady: assert property (o_pulse && $past(o_pulse) |->
        $stable(o_reverse)) else $error("direction moved inside pulse");
    chk_vib_blank: assert property (i_vibration |-> ##3 !$rose(o_pulse))
        else $error("pulse during vibration");
    chk_cal_sticky: assert property (o_cal_done |=> o_cal_done)
        else $error("calibration done dropped");
    chk_trim_frozen: assert property (o_cal_done && $past(o_cal_done) |->
        $stable(o_trim_a) && $stable(o_trim_b)) else $error("trim moved");
endmodule
bind sdp_pulse_seq sdp_pulse_seq_assertions #(.FWD_CYCLES(FWD_CYCLES),
    .REV_CYCLES(REV_CYCLES)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_vibration(i_vibration), .o_pulse(o_pulse), .o_reverse(o_reverse),
    .o_cal_done(o_cal_done), .o_trim_a(o_trim_a), .o_trim_b(o_trim_b));

/* File: speed_direction_pulse_output_bench.sv */
// Bench: tooth stimulus on both channels, host decode, pulse counts.
// Assumes shortened widths; fires on A falling forward, A rising reverse.
`include "sdp_defs.svh"
module speed_direction_pulse_output_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FW = 20;
    localparam int RV = 40;
    logic                 i_clk = 0;
    logic                 i_rst = 1;
    logic                 i_vibration = 0;
    sdp_pkg::sdp_sample_t i_ch_a = '0;
    sdp_pkg::sdp_sample_t i_ch_b = '0;
    logic                 o_pulse, o_reverse, o_cal_done;
    sdp_pkg::sdp_trim_t   o_trim_a, o_trim_b;
    logic          [15:0] n_fwd, n_rev, n_bad;
    int                   num_errors = 0;
    int                   num_checks = 0;
    int                   seed = 32'h4067B4A6;
    logic                 a = 0;
    always #5 i_clk = ~i_clk;
    sdp_pulse_seq #(.FWD_CYCLES(FW), .REV_CYCLES(RV)) u_sdp_pulse_seq
        (.i_clk(i_clk), .i_rst(i_rst), .i_ch_a(i_ch_a), .i_ch_b(i_ch_b),
        .i_vibration(i_vibration), .o_pulse(o_pulse), .o_reverse(o_reverse),
        .o_cal_done(o_cal_done), .o_trim_a(o_trim_a), .o_trim_b(o_trim_b));
    sdp_host_model #(.FWD(FW), .REV(RV)) u_sdp_host_model (.i_clk(i_clk),
        .i_pulse(o_pulse), .o_fwd(n_fwd), .o_rev(n_rev), .o_bad(n_bad));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Random level on the chosen side of the switch hysteresis
    function automatic logic [9:0] lvl(logic hi);
        logic [9:0] r;
        r = $random(seed);
        return hi ? {1'b1, r[8:0]} : {1'b0, r[8:0]} % 10'h1C0;
    endfunction
    // B is set first so the A edge lands in the wanted phase
    task automatic batch(int n, logic rev, logic run);
        int f0, r0, fires;
        f0 = n_fwd;
        r0 = n_rev;
        fires = 0;
        repeat (n)
        begin
            i_ch_b <= '{lvl(rev ? !a : a), 1'b1};
            repeat (40) @(posedge i_clk);
            a = !a;
            i_ch_a <= '{lvl(a), 1'b1};
            fires += (a == rev);
            repeat (40) @(posedge i_clk);
        end
        repeat (40) @(posedge i_clk);
        check("forward pulses", n_fwd - f0, run && !rev ? fires : 0);
        check("reverse pulses", n_rev - r0, run && rev ? fires : 0);
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
        check("trim", o_trim_a, {`SDP_GAIN_RST, `SDP_OFFS_RST});
        check("trim b", o_trim_b, {`SDP_GAIN_RST, `SDP_OFFS_RST});
        check("cal done", o_cal_done, 0);
        batch(5, 0, 0);
        check("cal done", o_cal_done, 1);
        batch(8, 0, 1);
        check("reverse flag", o_reverse, 0);
        batch(3, 1, 0);
        batch(8, 1, 1);
        check("reverse flag", o_reverse, 1);
        i_vibration <= 1;
        batch(3, 1, 0);
        i_vibration <= 0;
        batch(3, 1, 0);
        batch(8, 1, 1);
        check("odd widths", n_bad, 0);
        results();
    end
    // Run needs about 33 us; the limit leaves ample margin
    initial
    begin
        #100us;
        num_errors++;
        results();
    end
endmodule
